// ### design/sloa_defines.vh
`ifndef SLOA_DEFINES_VH
`define SLOA_DEFINES_VH
// addressing mode codes
`define SLOA_MODE_DIRECT 3'h0
`define SLOA_MODE_IND 3'h1
`define SLOA_MODE_POST 3'h2
`define SLOA_MODE_PRE 3'h3
`define SLOA_MODE_INDEXED 3'h4
`define SLOA_MODE_LITOFF 3'h5
`define SLOA_MODE_FILE 3'h6
`define SLOA_MODE_MOVEABS 3'h7
// stack floor, stack pointer register and default working register
`define SLOA_STACK_FLOOR 16'h0800
`define SLOA_SP_REG 4'hf
`define SLOA_WREG0 4'h0
// file register near field
`define SLOA_FILE_W 13
// mac prefetch registers
`define SLOA_XPA 4'h8
`define SLOA_XPB 4'h9
`define SLOA_YPA 4'ha
`define SLOA_YPB 4'hb
// mac post-modify amounts; branch and interrupt disable literal widths
`define SLOA_MAC_NONE 2'h0
`define SLOA_MAC_P2 2'h1
`define SLOA_MAC_P4 2'h2
`define SLOA_MAC_P6 2'h3
`define SLOA_BRA_W 16
`define SLOA_INTERRUPT_DISABLE_INSTR_W 14
`endif

// ### design/sloa_agu.v
`timescale 1ns/100ps
`include "sloa_defines.vh"
// one address generation lane: effective address and writeback value
module sloa_agu (
    input wire [2:0] mode,
    input wire [15:0] ptr,
    input wire [15:0] base,
    input wire [15:0] lit,
    input wire [15:0] modv,
    output reg [15:0] ea,
    output reg [15:0] wb_val,
    output reg wb_en
);
    always @* begin
        ea = ptr;
        wb_val = ptr;
        wb_en = 1'b0;
        case (mode)
            `SLOA_MODE_IND: ea = ptr;
            `SLOA_MODE_POST: begin
                ea = ptr; // RL14
                wb_val = ptr + modv;
                wb_en = 1'b1;
            end
            `SLOA_MODE_PRE: begin
                ea = ptr + modv; // RL14
                wb_val = ptr + modv;
                wb_en = 1'b1;
            end
            `SLOA_MODE_INDEXED: ea = ptr + base; // RL14
            `SLOA_MODE_LITOFF: ea = ptr + lit; // RL14
            `SLOA_MODE_FILE: ea = {3'h0, lit[`SLOA_FILE_W-1:0]}; // RL10
            `SLOA_MODE_MOVEABS: ea = lit; // RL12
            default: ea = ptr;
        endcase
    end
endmodule

// ### design/sloa_stack_check.v
`timescale 1ns/100ps
`include "sloa_defines.vh"
// stack limit and floor comparison for one effective address
module sloa_stack_check (
    input wire uses_sp,
    input wire is_push,
    input wire [15:0] sp_now,
    input wire [15:0] ea,
    input wire [15:0] limit,
    output wire err
);
    wire over;
    wire under;
    // a push at sp equal to the limit is allowed; the next one trips
    // any other pointer use of the stack register is held to the same bound
    assign over = (is_push ? sp_now : ea) > limit; // RL7
    assign under = ea < `SLOA_STACK_FLOOR; // RL8
    assign err = uses_sp && (over || under); // RL6
endmodule

// ### design/sloa_core.v
`timescale 1ns/100ps
`include "sloa_defines.vh"
// What this block does
// [RL1] stack pointer holds next free word; stack grows upward
// [RL2] pop predecrements pointer; push writes at pointer then increments
// [RL3] call push clears the top bit of the pushed pc high part
// [RL4] exception push places status low byte above pc top bit
// [RL5] stack limit has no reset value; bit 0 always zero
// [RL6] every effective address via stack pointer is checked against limit; code skips the stack register used as offset_reg
// [RL7] push at pointer equal limit is fine; following push traps
// [RL8] stack address below floor raises stack error trap
// [RL9] software avoids stack indirect read right after limit write
// [RL10] file register direct field is 13 bits, near 8192 bytes
// [RL11] register zero is default working reg; results to file or register
// [RL12] move instruction reaches the whole data space
// [RL13] three-operand: op1 register direct; op2 register, memory or literal
// [RL14] indexed, literal offset, pre- and post-modified address forms
// [RL15] move source and destination modes differ, share 4-bit offset field
// [RL16] mac prefetch pointers only registers eight to eleven
// [RL17] regs 8,9 to x read unit, 10,11 to y unit, in matching space
// [RL18] mac indexed only for register nine and register eleven
// [RL19] mac post-modify by 2, 4 or 6 bytes only
// [RL20] branch signed 16-bit literal; interrupt disable unsigned 14-bit
// [RL21] stack error trap is one pulse when offending address forms
module sloa_core (
    input wire mclk,
    input wire sys_rst,
    // operand request from decoder, one cycle
    input wire op_valid,
    input wire [2:0] src_mode,
    input wire [3:0] src_reg,
    input wire [2:0] dst_mode,
    input wire [3:0] dst_reg,
    input wire [3:0] offset_reg,
    input wire [15:0] literal,
    input wire [15:0] modifier,
    input wire is_move,
    input wire is_three_op,
    input wire [1:0] op2_kind,
    // stack operations
    input wire push_req,
    input wire pop_req,
    input wire call_push,
    input wire exc_push,
    input wire [23:0] pc_value,
    input wire [7:0] status_low_byte,
    input wire [15:0] push_data,
    // limit register write
    input wire limit_wr,
    input wire [15:0] limit_data,
    // mac prefetch
    input wire mac_valid,
    input wire [3:0] mac_x_reg,
    input wire [3:0] mac_y_reg,
    input wire mac_x_indexed,
    input wire mac_y_indexed,
    input wire [1:0] mac_x_post,
    input wire [1:0] mac_y_post,
    // branch and interrupt disable literals
    input wire [15:0] branch_lit,
    input wire [13:0] interrupt_disable_instr_lit,
    input wire [15:0] pc_now,
    // working register file (register view from the decoder side)
    input wire [255:0] default_working_reg_flat,
    // outputs
    output reg [15:0] src_ea,
    output reg [15:0] dst_ea,
    output reg [15:0] mem_wdata,
    output reg mem_we,
    output reg mem_re,
    output reg [3:0] wb_reg,
    output reg [15:0] wb_data,
    output reg wb_we,
    output reg [3:0] result_reg,
    output reg result_to_mem,
    output reg [15:0] x_read_address_unit,
    output reg [15:0] y_address_unit,
    output reg mac_bad,
    output reg [15:0] branch_target,
    output reg [13:0] interrupt_disable_instr_count,
    output reg [15:0] stack_top_pointer,
    output wire [15:0] stack_limit_reg,
    output reg stack_trap
);
    reg [15:0] limit_raw;
    reg [15:0] src_ptr;
    reg [15:0] dst_ptr;
    reg [15:0] base_operand_reg;
    wire [15:0] s_ea;
    wire [15:0] s_wb;
    wire s_wben;
    wire [15:0] d_ea;
    wire [15:0] d_wb;
    wire d_wben;
    wire src_sp;
    wire dst_sp;
    wire src_err;
    wire dst_err;
    wire stk_err;
    wire [15:0] sp_dec;
    wire [15:0] sp_inc;
    reg [15:0] push_word;
    reg [15:0] mac_x_step;
    reg [15:0] mac_y_step;
    wire mac_sel_ok;
    wire mac_wb_free;

    function [15:0] wsel;
        input [255:0] f;
        input [3:0] i;
        begin
            wsel = f[i*16 +: 16];
        end
    endfunction

    always @* begin
        src_ptr = wsel(default_working_reg_flat, src_reg);
        dst_ptr = wsel(default_working_reg_flat, dst_reg);
        base_operand_reg = wsel(default_working_reg_flat, offset_reg); // RL15
        if (src_reg == `SLOA_SP_REG)
            src_ptr = stack_top_pointer;
        if (dst_reg == `SLOA_SP_REG)
            dst_ptr = stack_top_pointer;
        if (offset_reg == `SLOA_SP_REG)
            base_operand_reg = stack_top_pointer;
    end

    // bit 0 always reads as zero
    assign stack_limit_reg = {limit_raw[15:1], 1'b0}; // RL5

    sloa_agu u_src (
        .mode(src_mode),
        .ptr(src_ptr),
        .base(base_operand_reg),
        .lit(literal),
        .modv(modifier),
        .ea(s_ea),
        .wb_val(s_wb),
        .wb_en(s_wben)
    );

    sloa_agu u_dst (
        .mode(dst_mode),
        .ptr(dst_ptr),
        .base(base_operand_reg),
        .lit(literal),
        .modv(modifier),
        .ea(d_ea),
        .wb_val(d_wb),
        .wb_en(d_wben)
    );

    assign sp_dec = stack_top_pointer - 16'h0002;
    assign sp_inc = stack_top_pointer + 16'h0002;
    assign src_sp = (op_valid && src_reg == `SLOA_SP_REG && src_mode != `SLOA_MODE_DIRECT
                    && src_mode != `SLOA_MODE_FILE && src_mode != `SLOA_MODE_MOVEABS)
                    || pop_req;
    assign dst_sp = (op_valid && dst_reg == `SLOA_SP_REG && dst_mode != `SLOA_MODE_DIRECT
                    && dst_mode != `SLOA_MODE_FILE && dst_mode != `SLOA_MODE_MOVEABS)
                    || push_req;

    // every address using the stack register as pointer is checked, not only pushes; as offset register it is not
    sloa_stack_check u_chk_src (
        .uses_sp(src_sp),
        .is_push(1'b0),
        .sp_now(stack_top_pointer),
        .ea(pop_req ? sp_dec : s_ea),
        .limit(stack_limit_reg),
        .err(src_err)
    );

    sloa_stack_check u_chk_dst (
        .uses_sp(dst_sp),
        .is_push(push_req),
        .sp_now(stack_top_pointer),
        .ea(push_req ? stack_top_pointer : d_ea),
        .limit(stack_limit_reg),
        .err(dst_err)
    );

    assign stk_err = src_err || dst_err; // RL6

    always @* begin
        push_word = push_data;
        if (call_push)
            // pc bits 22:16 zero-extended, so pc bit 23 is dropped and bit 7 of the pushed word is clear
            push_word = {9'h000, pc_value[22:16]}; // RL3
        if (exc_push)
            push_word = {status_low_byte, pc_value[23:16]}; // RL4
    end

    assign mac_sel_ok = (mac_x_reg == `SLOA_XPA || mac_x_reg == `SLOA_XPB)
                     && (mac_y_reg == `SLOA_YPA || mac_y_reg == `SLOA_YPB)
                     && (!mac_x_indexed || mac_x_reg == `SLOA_XPB)
                     && (!mac_y_indexed || mac_y_reg == `SLOA_YPB); // RL16 RL18

    // the single writeback port is free only when no other request owns it
    assign mac_wb_free = !op_valid && !push_req && !pop_req && mac_sel_ok;

    always @* begin
        case (mac_x_post)
            `SLOA_MAC_P2: mac_x_step = 16'h0002; // RL19
            `SLOA_MAC_P4: mac_x_step = 16'h0004;
            `SLOA_MAC_P6: mac_x_step = 16'h0006;
            default: mac_x_step = 16'h0000;
        endcase
        case (mac_y_post)
            `SLOA_MAC_P2: mac_y_step = 16'h0002; // RL19
            `SLOA_MAC_P4: mac_y_step = 16'h0004;
            `SLOA_MAC_P6: mac_y_step = 16'h0006;
            default: mac_y_step = 16'h0000;
        endcase
    end

    always @(posedge mclk) begin
        if (limit_wr)
            limit_raw <= limit_data; // RL5
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            stack_top_pointer <= `SLOA_STACK_FLOOR;
            src_ea <= 16'h0000;
            dst_ea <= 16'h0000;
            mem_wdata <= 16'h0000;
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            wb_reg <= 4'h0;
            wb_data <= 16'h0000;
            wb_we <= 1'b0;
            result_reg <= `SLOA_WREG0;
            result_to_mem <= 1'b0;
            x_read_address_unit <= 16'h0000;
            y_address_unit <= 16'h0000;
            mac_bad <= 1'b0;
            branch_target <= 16'h0000;
            interrupt_disable_instr_count <= 14'h0000;
            stack_trap <= 1'b0;
        end else begin
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            wb_we <= 1'b0;
            mac_bad <= 1'b0;
            // one pulse, the cycle after the offending address is formed
            stack_trap <= stk_err; // RL21
            branch_target <= pc_now + branch_lit; // RL20
            interrupt_disable_instr_count <= interrupt_disable_instr_lit; // RL20
            if (push_req) begin
                dst_ea <= stack_top_pointer; // RL2
                mem_wdata <= push_word;
                mem_we <= 1'b1;
                stack_top_pointer <= sp_inc; // RL1
            end else if (pop_req) begin
                src_ea <= sp_dec; // RL2
                mem_re <= 1'b1;
                stack_top_pointer <= sp_dec;
            end else if (op_valid) begin
                src_ea <= (is_three_op && op2_kind == 2'h2) ? literal & 16'h001f : s_ea; // RL13
                dst_ea <= d_ea;
                mem_re <= src_mode != `SLOA_MODE_DIRECT
                          && !(is_three_op && op2_kind != 2'h1); // RL13
                // result to memory when destination is any mode but register direct, else register
                result_to_mem <= dst_mode != `SLOA_MODE_DIRECT || (!is_move && !is_three_op
                                 && dst_mode == `SLOA_MODE_FILE); // RL11
                result_reg <= (dst_mode == `SLOA_MODE_DIRECT) ? dst_reg : `SLOA_WREG0; // RL11
                if (s_wben) begin
                    wb_reg <= src_reg; // RL14
                    wb_data <= s_wb;
                    wb_we <= 1'b1;
                    if (src_reg == `SLOA_SP_REG)
                        stack_top_pointer <= s_wb;
                end else if (d_wben) begin
                    wb_reg <= dst_reg; // RL15
                    wb_data <= d_wb;
                    wb_we <= 1'b1;
                    if (dst_reg == `SLOA_SP_REG)
                        stack_top_pointer <= d_wb;
                end
            end
            if (mac_valid) begin
                mac_bad <= !mac_sel_ok; // RL16
                // x pair goes to the x read unit, y pair to the y unit
                x_read_address_unit <= mac_x_indexed
                    ? wsel(default_working_reg_flat, mac_x_reg) + wsel(default_working_reg_flat, 4'hc)
                    : wsel(default_working_reg_flat, mac_x_reg); // RL17 RL18
                y_address_unit <= mac_y_indexed
                    ? wsel(default_working_reg_flat, mac_y_reg) + wsel(default_working_reg_flat, 4'hc)
                    : wsel(default_working_reg_flat, mac_y_reg); // RL17
                // one pointer update per cycle: x wins, a y update is lost when both step
                if (mac_wb_free && mac_x_post != 2'h0) begin
                    wb_reg <= mac_x_reg; // RL19
                    wb_data <= wsel(default_working_reg_flat, mac_x_reg) + mac_x_step;
                    wb_we <= 1'b1;
                end else if (mac_wb_free) begin
                    wb_reg <= mac_y_reg;
                    wb_data <= wsel(default_working_reg_flat, mac_y_reg) + mac_y_step;
                    wb_we <= mac_y_post != 2'h0;
                end
            end
        end
    end
endmodule

// ### test/sloa_core_props.sv
`timescale 1ns/100ps
module sloa_core_props (
    input wire mclk,
    input wire sys_rst,
    input wire op_valid,
    input wire push_req,
    input wire pop_req,
    input wire call_push,
    input wire exc_push,
    input wire [23:0] pc_value,
    input wire [7:0] status_low_byte,
    input wire limit_wr,
    input wire [15:0] limit_data,
    input wire mac_valid,
    input wire [3:0] mac_x_reg,
    input wire [3:0] mac_y_reg,
    input wire mac_x_indexed,
    input wire mac_y_indexed,
    input wire [15:0] src_ea,
    input wire [15:0] dst_ea,
    input wire [15:0] mem_wdata,
    input wire mem_we,
    input wire mac_bad,
    input wire [15:0] stack_top_pointer,
    input wire [15:0] stack_limit_reg,
    input wire stack_trap
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire pop = pop_req && !push_req;
    wire [15:0] sp = stack_top_pointer;
    wire x_ok = mac_x_reg == 4'h9 || (mac_x_reg == 4'h8 && !mac_x_indexed);
    wire y_ok = mac_y_reg == 4'hb || (mac_y_reg == 4'ha && !mac_y_indexed);
    sequence s_push_at_sp;
        mem_we && dst_ea == $past(sp);
    endsequence
    sequence s_ok_push;
        push_req && sp <= stack_limit_reg && sp >= 16'h0800;
    endsequence
    a_push_at_pointer: assert property (push_req |=> s_push_at_sp)
        else $error("push address is not the old pointer");
    a_push_post_inc: assert property (s_ok_push |=> sp == $past(sp) + 16'h2)
        else $error("pointer did not step up by two");
    a_pop_pre_dec: assert property (pop |=> src_ea == $past(sp) - 16'h2)
        else $error("pop address is not pointer minus two");
    a_limit_even: assert property (stack_limit_reg[0] == 1'b0)
        else $error("limit bit zero set");
    a_limit_load: assert property (limit_wr |=> stack_limit_reg == {$past(limit_data[15:1]), 1'b0})
        else $error("limit not loaded");
    a_equal_no_trap: assert property (s_ok_push |=> !stack_trap)
        else $error("trap on push within limit");
    a_over_trap: assert property (push_req && sp > stack_limit_reg |=> stack_trap)
        else $error("no trap past limit");
    a_under_trap: assert property (pop && sp < 16'h0802 |=> stack_trap)
        else $error("no trap below floor");
    a_exc_word: assert property (push_req && exc_push |=>
        mem_wdata == {$past(status_low_byte), $past(pc_value[23:16])})
        else $error("exception push word wrong");
    a_call_word: assert property (push_req && call_push && !exc_push |=>
        mem_wdata == {9'h000, $past(pc_value[22:16])})
        else $error("call push word wrong");
    a_mac_select: assert property (mac_valid |=> mac_bad == !$past(x_ok && y_ok))
        else $error("mac selection flag wrong");
    a_trap_cause: assert property (stack_trap |-> $past(push_req || pop_req || op_valid))
        else $error("trap without stack request");
endmodule
bind sloa_core sloa_core_props u_props (
    .mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid), .push_req(push_req),
    .pop_req(pop_req), .call_push(call_push), .exc_push(exc_push), .pc_value(pc_value),
    .status_low_byte(status_low_byte), .limit_wr(limit_wr), .limit_data(limit_data),
    .mac_valid(mac_valid), .mac_x_reg(mac_x_reg), .mac_y_reg(mac_y_reg),
    .mac_x_indexed(mac_x_indexed), .mac_y_indexed(mac_y_indexed), .src_ea(src_ea),
    .dst_ea(dst_ea), .mem_wdata(mem_wdata), .mem_we(mem_we), .mac_bad(mac_bad),
    .stack_top_pointer(stack_top_pointer), .stack_limit_reg(stack_limit_reg),
    .stack_trap(stack_trap));

// ### test/sloa_mem_model.sv
`timescale 1ns/100ps
module sloa_mem_model (
    input wire mclk,
    input wire mem_we,
    input wire [15:0] dst_ea,
    input wire [15:0] mem_wdata,
    input wire stack_trap
);
    reg [15:0] mem [0:127];
    integer traps = 0;
    // a trapped push is cancelled, as exception handling would do
    always @(posedge mclk) begin
        if (stack_trap)
            traps <= traps + 1;
        else if (mem_we)
            mem[dst_ea[7:1]] <= mem_wdata;
    end
endmodule

// ### test/stack_limit_and_operand_addressing_tb_top.sv
`timescale 1ns/100ps
module stack_limit_and_operand_addressing_tb_top;
    logic mclk = 0, sys_rst = 1, op_valid = 0, is_move = 1, is_three_op = 0, push_req = 0;
    logic pop_req = 0, call_push = 0, exc_push = 0, limit_wr = 0, mac_valid = 0;
    logic mac_x_indexed = 0, mac_y_indexed = 0;
    logic [1:0] op2_kind = 0, mac_x_post = 2'h1, mac_y_post = 2'h3;
    logic [2:0] src_mode = 0, dst_mode = 0;
    logic [3:0] src_reg = 4'h1, dst_reg = 4'h3, offset_reg = 4'h2, mac_x_reg = 0, mac_y_reg = 0;
    logic [15:0] literal = 16'hef36, modifier = 16'hfffe, push_data = 16'h4d2e;
    logic [15:0] limit_data = 0, branch_lit = 16'hff80, pc_now = 16'h0400;
    logic [23:0] pc_value = 24'ha5b6c7;
    logic [7:0] status_low_byte = 8'h3c;
    logic [13:0] interrupt_disable_instr_lit = 14'h2abc;
    logic [255:0] default_working_reg_flat;
    wire [15:0] src_ea, dst_ea, mem_wdata, wb_data, x_read_address_unit, y_address_unit;
    wire [15:0] branch_target, stack_top_pointer, stack_limit_reg;
    wire [3:0] wb_reg, result_reg;
    wire [13:0] interrupt_disable_instr_count;
    wire mem_we, mem_re, wb_we, result_to_mem, mac_bad, stack_trap;
    integer n_fail = 0, total_checks = 0, i;
    always #20 mclk = ~mclk;
    sloa_core dut (
        .mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid), .src_mode(src_mode),
        .src_reg(src_reg), .dst_mode(dst_mode), .dst_reg(dst_reg), .offset_reg(offset_reg),
        .literal(literal), .modifier(modifier), .is_move(is_move), .is_three_op(is_three_op),
        .op2_kind(op2_kind), .push_req(push_req), .pop_req(pop_req), .call_push(call_push),
        .exc_push(exc_push), .pc_value(pc_value), .status_low_byte(status_low_byte),
        .push_data(push_data), .limit_wr(limit_wr), .limit_data(limit_data),
        .mac_valid(mac_valid), .mac_x_reg(mac_x_reg), .mac_y_reg(mac_y_reg),
        .mac_x_indexed(mac_x_indexed), .mac_y_indexed(mac_y_indexed),
        .mac_x_post(mac_x_post), .mac_y_post(mac_y_post), .branch_lit(branch_lit),
        .interrupt_disable_instr_lit(interrupt_disable_instr_lit), .pc_now(pc_now), .default_working_reg_flat(default_working_reg_flat), .src_ea(src_ea),
        .dst_ea(dst_ea), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
        .wb_reg(wb_reg), .wb_data(wb_data), .wb_we(wb_we), .result_reg(result_reg),
        .result_to_mem(result_to_mem), .x_read_address_unit(x_read_address_unit),
        .y_address_unit(y_address_unit), .mac_bad(mac_bad), .branch_target(branch_target),
        .interrupt_disable_instr_count(interrupt_disable_instr_count), .stack_top_pointer(stack_top_pointer),
        .stack_limit_reg(stack_limit_reg), .stack_trap(stack_trap));
    sloa_mem_model mdl (.mclk(mclk), .mem_we(mem_we), .dst_ea(dst_ea),
        .mem_wdata(mem_wdata), .stack_trap(stack_trap));
    initial for (i = 0; i < 16; i++) default_working_reg_flat[16*i+:16] = {4'h0, i[3:0], 8'h08};
    task wrap_up;
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one cycle of write, then an idle cycle before any stack access
    task lim(input [15:0] v);
        @(negedge mclk) limit_wr = 1;
        limit_data = v;
        @(negedge mclk) limit_wr = 0;
        chk("limit", {v[15:1], 1'b0}, stack_limit_reg);
    endtask
    task stk(input p, input e, input c, input [15:0] ea, input [15:0] sp, input tr);
        @(negedge mclk) push_req = p;
        pop_req = !p;
        exc_push = e;
        call_push = c;
        @(negedge mclk) push_req = 0;
        pop_req = 0;
        chk("ea", ea, p ? dst_ea : src_ea);
        if (!tr) chk("sp", sp, stack_top_pointer);
        chk("trap", {15'h0, tr}, {15'h0, stack_trap});
        chk("mem_we", {15'h0, p}, {15'h0, mem_we});
        chk("mem_re", {15'h0, !p}, {15'h0, mem_re});
    endtask
    task t_stack;
        chk("sp_reset", 16'h0800, stack_top_pointer);
        lim(16'h0803);
        stk(1, 1, 0, 16'h0800, 16'h0802, 0);
        chk("exc_word", 16'h3ca5, mem_wdata);
        stk(1, 0, 1, 16'h0802, 16'h0804, 0);
        chk("call_word", 16'h0025, mem_wdata);
        stk(0, 0, 0, 16'h0802, 16'h0802, 0);
        stk(0, 0, 0, 16'h0800, 16'h0800, 0);
        stk(0, 0, 0, 16'h07fe, 16'h0, 1);
        @(negedge mclk) sys_rst = 1;
        @(negedge mclk) sys_rst = 0;
        lim(16'h0800);
        stk(1, 0, 0, 16'h0800, 16'h0802, 0);
        chk("push_word", 16'h4d2e, mem_wdata);
        stk(1, 0, 0, 16'h0802, 16'h0, 1);
        @(negedge mclk);
        chk("traps", 16'h2, mdl.traps[15:0]);
        chk("mem_call", 16'h0025, mdl.mem[1]);
    endtask
    task t_modes;
        reg [15:0] x [1:7];
        integer m;
        x = '{16'h0108, 16'h0108, 16'h0106, 16'h0310, 16'hf03e, 16'h0f36, 16'hef36};
        for (m = 1; m < 8; m++) begin
            @(negedge mclk) op_valid = 1;
            src_mode = m[2:0];
            @(negedge mclk) op_valid = 0;
            chk("src_ea", x[m], src_ea);
            if (m == 2 || m == 3) chk("wb_data", 16'h0106, wb_data);
            if (m == 2 || m == 3) chk("wb_reg", 16'h0001, {12'h0, wb_reg});
            chk("wb_we", {15'h0, (m == 2 || m == 3)}, {15'h0, wb_we});
            chk("mem_re", 16'h0001, {15'h0, mem_re});
            if (m == 6) chk("file_ea", 16'h0f36, src_ea);
            if (m == 7) chk("abs_ea", 16'hef36, src_ea);
        end
        chk("res_reg", 16'h0003, {12'h0, result_reg});
        chk("res_mem", 16'h0000, {15'h0, result_to_mem});
    endtask
    task op(input mv, input three, input [1:0] k, input [2:0] sm, input [2:0] dm);
        @(negedge mclk) op_valid = 1;
        {is_move, is_three_op, op2_kind, src_mode, dst_mode} = {mv, three, k, sm, dm};
        @(negedge mclk) op_valid = 0;
    endtask
    task t_ops;
        op(0, 1, 2'h2, 3'h1, 3'h2);
        chk("lit_op2", 16'h0016, src_ea);
        chk("lit_mem_re", 16'h0000, {15'h0, mem_re});
        chk("post_dst_ea", 16'h0308, dst_ea);
        chk("dst_wb_reg", 16'h0003, {12'h0, wb_reg});
        chk("dst_wb_data", 16'h0306, wb_data);
        chk("op_res_mem", 16'h0001, {15'h0, result_to_mem});
        chk("op_res_reg", 16'h0000, {12'h0, result_reg});
        op(0, 1, 2'h1, 3'h4, 3'h4);
        chk("idx_src_ea", 16'h0310, src_ea);
        chk("idx_dst_ea", 16'h0510, dst_ea);
        chk("idx_mem_re", 16'h0001, {15'h0, mem_re});
        chk("idx_wb_we", 16'h0000, {15'h0, wb_we});
        op(0, 0, 2'h0, 3'h1, 3'h6);
        chk("file_dst_ea", 16'h0f36, dst_ea);
        chk("file_res_mem", 16'h0001, {15'h0, result_to_mem});
        chk("file_res_reg", 16'h0000, {12'h0, result_reg});
    endtask
    task mac(input [3:0] xr, input [3:0] yr, input xi, input yi, input bad,
        input [15:0] ex, input [15:0] ey, input [15:0] ew);
        @(negedge mclk) mac_valid = 1;
        {mac_x_reg, mac_y_reg, mac_x_indexed, mac_y_indexed} = {xr, yr, xi, yi};
        @(negedge mclk) mac_valid = 0;
        chk("mac_bad", {15'h0, bad}, {15'h0, mac_bad});
        if (!bad) chk("x_unit", ex, x_read_address_unit);
        if (!bad) chk("y_unit", ey, y_address_unit);
        if (!bad) chk("ptr_step", ew, wb_data);
        chk("step_we", {15'h0, !bad}, {15'h0, wb_we});
    endtask
    initial begin
        #(40 * 3000);
        n_fail++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk) sys_rst = 0;
        t_stack;
        chk("branch", 16'h0380, branch_target);
        chk("interrupt_disable_instr", 16'h2abc, {2'h0, interrupt_disable_instr_count});
        t_modes;
        t_ops;
        mac(4'h8, 4'ha, 0, 0, 0, 16'h0808, 16'h0a08, 16'h080a);
        mac(4'h9, 4'hb, 1, 1, 0, 16'h1510, 16'h1710, 16'h090a);
        mac(4'h8, 4'hb, 1, 0, 1, 16'h0, 16'h0, 16'h0);
        mac(4'ha, 4'hb, 0, 0, 1, 16'h0, 16'h0, 16'h0);
        mac(4'h9, 4'h8, 0, 0, 1, 16'h0, 16'h0, 16'h0);
        mac_x_post = 2'h2;
        mac(4'h9, 4'hb, 0, 0, 0, 16'h0908, 16'h0b08, 16'h090c);
        mac_x_post = 2'h0;
        mac(4'h8, 4'ha, 0, 0, 0, 16'h0808, 16'h0a08, 16'h0a0e);
        wrap_up;
    end
endmodule
